// ### gio_regs.vh
`ifndef GIO_REGS_VH
`define GIO_REGS_VH

// Bank numbers, taken from address bits [7:5].
`define GIO_BANK_P1 0
`define GIO_BANK_P4 1
`define GIO_BANK_P9 2
`define GIO_BANK_PA 3
`define GIO_BANK_PB 4
`define GIO_BANK_PC 5
`define GIO_BANK_PD 6
`define GIO_BANK_PF 7
`define GIO_NUM_BANKS 8

// Register select within a bank, taken from address bits [4:2].
`define GIO_REG_DIR   3'h0
`define GIO_REG_LATCH 3'h1
`define GIO_REG_VIEW  3'h2
`define GIO_REG_PULL  3'h3
`define GIO_REG_DRAIN 3'h4

// Address field positions.
`define GIO_ADDR_BANK_HI 7
`define GIO_ADDR_BANK_LO 5
`define GIO_ADDR_REG_HI  4
`define GIO_ADDR_REG_LO  2
`define GIO_ADDR_TOP_LO  8

// Reset values.
`define GIO_DIR_RST   8'h00
`define GIO_LATCH_RST 8'h00
`define GIO_PULL_RST  8'h00
`define GIO_DRAIN_RST 8'h00

// Value returned when the write-only direction location is read.
`define GIO_DIR_READ  8'h00

// AXI responses.
`define GIO_RESP_OKAY   2'h0
`define GIO_RESP_SLVERR 2'h2

`endif

// ### gio_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "gio_regs.vh"

module gio_bank #(
	parameter W       = 8,
	parameter HAS_DIR = 1,
	parameter HAS_PU  = 0,
	parameter HAS_OD  = 0
) (
	input  wire         clk,
	input  wire         arst_n,
	input  wire         wr_en,
	input  wire [2:0]   wr_sel,
	input  wire [7:0]   wr_data,
	input  wire [2:0]   rd_sel,
	output wire [7:0]   rd_data,
	output wire         wr_hit,
	output wire         rd_hit,
	input  wire [W-1:0] pin_in,
	output wire [W-1:0] pin_out,
	output wire [W-1:0] pin_oe,
	output wire [W-1:0] pin_pu
);

	function exists;
		input [2:0] sel;
		begin
			case (sel)
				`GIO_REG_DIR:   exists = (HAS_DIR != 0);
				`GIO_REG_LATCH: exists = (HAS_DIR != 0);
				`GIO_REG_VIEW:  exists = 1'b1;
				`GIO_REG_PULL:  exists = (HAS_PU != 0);
				`GIO_REG_DRAIN: exists = (HAS_OD != 0);
				default:        exists = 1'b0;
			endcase
		end
	endfunction

	// Byte-wide constants are cut to the bank width on purpose.
	localparam [7:0] DIR_RST   = `GIO_DIR_RST;
	localparam [7:0] LATCH_RST = `GIO_LATCH_RST;
	localparam [7:0] PULL_RST  = `GIO_PULL_RST;
	localparam [7:0] DRAIN_RST = `GIO_DRAIN_RST;
	localparam [7:0] DIR_READ  = `GIO_DIR_READ;

	wire [W-1:0] dir_r;
	wire [W-1:0] latch_r;
	wire [W-1:0] pu_r;
	wire [W-1:0] od_r;
	wire         wr_ok;
	wire [W-1:0] view_w;
	reg  [W-1:0] mux_w;

	assign wr_hit = exists(wr_sel);
	assign rd_hit = exists(rd_sel);
	assign wr_ok  = wr_en & wr_hit;

	////////////////////////////////////////////////////////////////////////
	// Input-only banks get no direction or latch flops at all.
	generate
		if (HAS_DIR != 0) begin : g_io
			reg [W-1:0] dir_q;
			reg [W-1:0] latch_q;
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					dir_q   <= DIR_RST[W-1:0];
					latch_q <= LATCH_RST[W-1:0];
				end else begin
					if (wr_ok && wr_sel == `GIO_REG_DIR)
						dir_q <= wr_data[W-1:0];
					if (wr_ok && wr_sel == `GIO_REG_LATCH)
						latch_q <= wr_data[W-1:0];
				end
			end
			assign dir_r   = dir_q;
			assign latch_r = latch_q;
		end else begin : g_in
			assign dir_r   = {W{1'b0}};
			assign latch_r = {W{1'b0}};
		end
		if (HAS_PU != 0) begin : g_pu
			reg [W-1:0] pu_q;
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					pu_q <= PULL_RST[W-1:0];
				else if (wr_ok && wr_sel == `GIO_REG_PULL)
					pu_q <= wr_data[W-1:0];
			end
			assign pu_r = pu_q;
		end else begin : g_nopu
			assign pu_r = {W{1'b0}};
		end
		if (HAS_OD != 0) begin : g_od
			reg [W-1:0] od_q;
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					od_q <= DRAIN_RST[W-1:0];
				else if (wr_ok && wr_sel == `GIO_REG_DRAIN)
					od_q <= wr_data[W-1:0];
			end
			assign od_r = od_q;
		end else begin : g_nood
			assign od_r = {W{1'b0}};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Pin drive. In open-drain mode a high latch turns the driver off so the
	// line floats to its external pull.
	assign pin_out = latch_r;
	assign pin_oe  = dir_r & (~od_r | ~latch_r);
	assign pin_pu  = pu_r & ~dir_r;

	assign view_w = (dir_r & latch_r) | (~dir_r & pin_in);

	always @* begin
		case (rd_sel)
			`GIO_REG_DIR:   mux_w = DIR_READ[W-1:0];
			`GIO_REG_LATCH: mux_w = latch_r;
			`GIO_REG_VIEW:  mux_w = view_w;
			`GIO_REG_PULL:  mux_w = pu_r;
			`GIO_REG_DRAIN: mux_w = od_r;
			default:        mux_w = {W{1'b0}};
		endcase
	end

	generate
		if (W < 8) begin : g_pad
			assign rd_data = {{(8-W){1'b0}}, mux_w};
		end else begin : g_full
			assign rd_data = mux_w[7:0];
		end
	endgenerate

endmodule
`default_nettype wire

// ### gio_top.v
// Functional notes
// - Per-pin direction bit on bidirectional ports
// - Per-pin output latch drives output pins
// - Readable pin-state view on every port
// - Input-only ports lack direction and latch
// - Ports A-D have switchable input pull-ups
// - Ports A-C select push-pull or open-drain
// - Port 1: eight bidirectional pins, no pull-up or open-drain
// - Port 4 (8) and 9 (4) input-only
// - Direction one is output; resets to zero
// - Direction location is write-only, reads zero
// - View shows latch for outputs, pin otherwise
// - Latch read/write resets zero; view ignores writes
`timescale 1ns/1ps
`default_nettype none
`include "gio_regs.vh"

module gio_top (
	input  wire        clk,
	input  wire        arst_n,
	// AXI4-Lite slave.
	input  wire [31:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Port 1.
	input  wire [7:0]  p1_in,
	output wire [7:0]  p1_out,
	output wire [7:0]  p1_oe,
	// Ports 4 and 9, input-only, shared with the converter inputs.
	input  wire [7:0]  p4_in,
	input  wire [3:0]  p9_in,
	// Port A.
	input  wire [3:0]  pa_in,
	output wire [3:0]  pa_out,
	output wire [3:0]  pa_oe,
	output wire [3:0]  pa_pu,
	// Port B.
	input  wire [7:0]  pb_in,
	output wire [7:0]  pb_out,
	output wire [7:0]  pb_oe,
	output wire [7:0]  pb_pu,
	// Port C.
	input  wire [7:0]  pc_in,
	output wire [7:0]  pc_out,
	output wire [7:0]  pc_oe,
	output wire [7:0]  pc_pu,
	// Port D.
	input  wire [7:0]  pd_in,
	output wire [7:0]  pd_out,
	output wire [7:0]  pd_oe,
	output wire [7:0]  pd_pu,
	// Port F.
	input  wire [7:0]  pf_in,
	output wire [7:0]  pf_out,
	output wire [7:0]  pf_oe
);

	////////////////////////////////////////////////////////////////////////
	// Write channel. Address and data are caught independently so the master
	// may present them in either order; the write itself happens once both
	// are held and no response is still waiting.
	reg        aw_have_r;
	reg [7:0]  aw_addr_r;
	reg        aw_top_ok_r;
	reg        w_have_r;
	reg [7:0]  w_data_r;
	reg        w_strb_r;
	reg        bvalid_r;
	reg [1:0]  bresp_r;

	wire       aw_fire;
	wire       w_fire;
	wire       wr_fire;
	wire [2:0] wr_bank;
	wire [2:0] wr_sel;
	wire [7:0] wr_en_vec;
	wire [7:0] wr_hit_vec;
	wire       wr_good;

	assign s_axi_awready = ~aw_have_r & ~bvalid_r;
	assign s_axi_wready  = ~w_have_r & ~bvalid_r;
	assign aw_fire       = s_axi_awvalid & s_axi_awready;
	assign w_fire        = s_axi_wvalid & s_axi_wready;
	assign wr_fire       = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_bank       = aw_addr_r[`GIO_ADDR_BANK_HI:`GIO_ADDR_BANK_LO];
	assign wr_sel        = aw_addr_r[`GIO_ADDR_REG_HI:`GIO_ADDR_REG_LO];
	assign wr_good       = aw_top_ok_r & wr_hit_vec[wr_bank];
	// Registers are at most eight bits wide, so only the lowest byte lane matters.
	assign wr_en_vec     = (wr_fire & w_strb_r & aw_top_ok_r) ? (8'h01 << wr_bank) : 8'h00;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_have_r   <= 1'b0;
			aw_addr_r   <= 8'h00;
			aw_top_ok_r <= 1'b0;
			w_have_r    <= 1'b0;
			w_data_r    <= 8'h00;
			w_strb_r    <= 1'b0;
			bvalid_r    <= 1'b0;
			bresp_r     <= `GIO_RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_have_r   <= 1'b1;
				aw_addr_r   <= s_axi_awaddr[7:0];
				aw_top_ok_r <= (s_axi_awaddr[31:`GIO_ADDR_TOP_LO] == 24'h000000);
			end
			if (w_fire) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata[7:0];
				w_strb_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_good ? `GIO_RESP_OKAY : `GIO_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	////////////////////////////////////////////////////////////////////////
	// Read channel. The view is sampled into rdata at the address handshake,
	// so the value returned is the pin state of that edge.
	reg        rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0]  rresp_r;

	wire        ar_fire;
	wire [2:0]  rd_bank;
	wire [2:0]  rd_sel;
	wire [63:0] rd_flat;
	wire [7:0]  rd_hit_vec;
	wire        rd_good;

	assign s_axi_arready = ~rvalid_r;
	assign ar_fire       = s_axi_arvalid & s_axi_arready;
	assign rd_bank       = s_axi_araddr[`GIO_ADDR_BANK_HI:`GIO_ADDR_BANK_LO];
	assign rd_sel        = s_axi_araddr[`GIO_ADDR_REG_HI:`GIO_ADDR_REG_LO];
	assign rd_good       = (s_axi_araddr[31:`GIO_ADDR_TOP_LO] == 24'h000000) & rd_hit_vec[rd_bank];

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= `GIO_RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_good ? {24'h000000, rd_flat[8*rd_bank +: 8]} : 32'h00000000;
			rresp_r  <= rd_good ? `GIO_RESP_OKAY : `GIO_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	////////////////////////////////////////////////////////////////////////
	// Port banks.
	gio_bank #(.W(8), .HAS_DIR(1), .HAS_PU(0), .HAS_OD(0)) u_p1 (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_P1]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_P1 +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_P1]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_P1]),
		.pin_in  (p1_in),
		.pin_out (p1_out),
		.pin_oe  (p1_oe),
		.pin_pu  ()
	);

	gio_bank #(.W(8), .HAS_DIR(0), .HAS_PU(0), .HAS_OD(0)) u_p4 (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_P4]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_P4 +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_P4]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_P4]),
		.pin_in  (p4_in),
		.pin_out (),
		.pin_oe  (),
		.pin_pu  ()
	);

	gio_bank #(.W(4), .HAS_DIR(0), .HAS_PU(0), .HAS_OD(0)) u_p9 (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_P9]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_P9 +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_P9]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_P9]),
		.pin_in  (p9_in),
		.pin_out (),
		.pin_oe  (),
		.pin_pu  ()
	);

	gio_bank #(.W(4), .HAS_DIR(1), .HAS_PU(1), .HAS_OD(1)) u_pa (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_PA]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_PA +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_PA]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_PA]),
		.pin_in  (pa_in),
		.pin_out (pa_out),
		.pin_oe  (pa_oe),
		.pin_pu  (pa_pu)
	);

	gio_bank #(.W(8), .HAS_DIR(1), .HAS_PU(1), .HAS_OD(1)) u_pb (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_PB]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_PB +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_PB]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_PB]),
		.pin_in  (pb_in),
		.pin_out (pb_out),
		.pin_oe  (pb_oe),
		.pin_pu  (pb_pu)
	);

	gio_bank #(.W(8), .HAS_DIR(1), .HAS_PU(1), .HAS_OD(1)) u_pc (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_PC]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_PC +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_PC]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_PC]),
		.pin_in  (pc_in),
		.pin_out (pc_out),
		.pin_oe  (pc_oe),
		.pin_pu  (pc_pu)
	);

	gio_bank #(.W(8), .HAS_DIR(1), .HAS_PU(1), .HAS_OD(0)) u_pd (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_PD]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_PD +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_PD]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_PD]),
		.pin_in  (pd_in),
		.pin_out (pd_out),
		.pin_oe  (pd_oe),
		.pin_pu  (pd_pu)
	);

	gio_bank #(.W(8), .HAS_DIR(1), .HAS_PU(0), .HAS_OD(0)) u_pf (
		.clk     (clk),
		.arst_n  (arst_n),
		.wr_en   (wr_en_vec[`GIO_BANK_PF]),
		.wr_sel  (wr_sel),
		.wr_data (w_data_r),
		.rd_sel  (rd_sel),
		.rd_data (rd_flat[8*`GIO_BANK_PF +: 8]),
		.wr_hit  (wr_hit_vec[`GIO_BANK_PF]),
		.rd_hit  (rd_hit_vec[`GIO_BANK_PF]),
		.pin_in  (pf_in),
		.pin_out (pf_out),
		.pin_oe  (pf_oe),
		.pin_pu  ()
	);

endmodule
`default_nettype wire

// ### gio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gio_pin_model #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] ext,
	input  wire logic [W-1:0] out,
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] pu,
	output logic      [W-1:0] lvl
);
	// A released pin shows the pull-up, else whatever the board puts there.
	assign lvl = (oe & out) | (~oe & (pu | ext));
endmodule
`default_nettype wire

// ### gio_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gio_top_checker (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [7:0]  p1_out,
	input wire logic [7:0]  p1_oe,
	input wire logic [7:0]  p4_in,
	input wire logic [3:0]  p9_in,
	input wire logic [7:0]  pb_oe,
	input wire logic [7:0]  pb_pu
);
	logic rd_take;
	assign rd_take = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_wr_answer: assert property (s_wr_take |=> s_b_late) else $error("write answer off");
	a_rd_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_pin_commit: assert property ($changed({p1_out, p1_oe, pb_oe, pb_pu}) |-> $rose(s_axi_bvalid))
		else $error("pins moved without a write");
	a_pull_input: assert property ((pb_pu & pb_oe) == 8'h00) else $error("pull-up on output");
	a_dir_blind: assert property (rd_take && s_axi_araddr[31:8] == 24'h0 && s_axi_araddr[4:2] == 3'h0
		|=> s_axi_rdata == 32'h0) else $error("direction readable");
	a_p4_view: assert property (rd_take && s_axi_araddr == 32'h28
		|=> s_axi_rdata == {24'h0, $past(p4_in)}) else $error("port 4 view wrong");
	a_p9_view: assert property (rd_take && s_axi_araddr == 32'h48
		|=> s_axi_rdata == {28'h0, $past(p9_in)}) else $error("port 9 view wrong");
	a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule
bind gio_top gio_top_checker u_gio_top_checker (.*);
`default_nettype wire

// ### general_io_port_group_bench.sv
`timescale 1ns/1ps
`default_nettype none
module general_io_port_group_bench;
	logic clk = 0, arst_n = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rnd = 32'hA645;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] p1_in, p1_out, p1_oe, p4_in = 0, pf_in, pf_out, pf_oe;
	logic [7:0] pb_in, pb_out, pb_oe, pb_pu, pc_in, pc_out, pc_oe, pc_pu, pd_in, pd_out, pd_oe, pd_pu;
	logic [3:0] p9_in = 0, pa_in, pa_out, pa_oe, pa_pu;
	logic [7:0] ext [8] = '{default: 8'h00};
	int error_cnt = 0, check_count = 0;
	gio_top u_gio_top (.*);
	gio_pin_model #(.W(8)) u_gio_pin_model_1 (.ext(ext[0]), .out(p1_out), .oe(p1_oe), .pu(8'h00), .lvl(p1_in));
	gio_pin_model #(.W(4)) u_gio_pin_model_a (.ext(ext[3][3:0]), .out(pa_out), .oe(pa_oe), .pu(pa_pu), .lvl(pa_in));
	gio_pin_model #(.W(8)) u_gio_pin_model_b (.ext(ext[4]), .out(pb_out), .oe(pb_oe), .pu(pb_pu), .lvl(pb_in));
	gio_pin_model #(.W(8)) u_gio_pin_model_c (.ext(ext[5]), .out(pc_out), .oe(pc_oe), .pu(pc_pu), .lvl(pc_in));
	gio_pin_model #(.W(8)) u_gio_pin_model_d (.ext(ext[6]), .out(pd_out), .oe(pd_oe), .pu(pd_pu), .lvl(pd_in));
	gio_pin_model #(.W(8)) u_gio_pin_model_f (.ext(ext[7]), .out(pf_out), .oe(pf_oe), .pu(8'h00), .lvl(pf_in));
	initial begin
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rb();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd[7:0];
	endfunction
	function automatic logic [23:0] pins(input int b);
		case (b)
			0: pins = {p1_oe, p1_out, 8'h00};
			3: pins = {4'h0, pa_oe, 4'h0, pa_out, 4'h0, pa_pu};
			4: pins = {pb_oe, pb_out, pb_pu};
			5: pins = {pc_oe, pc_out, pc_pu};
			6: pins = {pd_oe, pd_out, pd_pu};
			7: pins = {pf_oe, pf_out, 8'h00};
			default: pins = 24'h0;
		endcase
	endfunction
	// Open drain only ever pulls low, so a high latch bit releases the pin.
	function automatic logic [23:0] exp_pins(input logic [7:0] d, l, p, o);
		return {d & ~(o & l), l, p & ~d};
	endfunction
	function automatic logic [7:0] exp_view(input logic [7:0] d, l, p, e, m);
		return ((l & d) | (~d & (p | e))) & m;
	endfunction
	task automatic ck(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		logic ak, wk;
		logic [7:0] r;
		ak = 0;
		wk = 0;
		r = rb();
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awprot <= r[2:0];
		s_axi_wstrb[3:1] <= r[5:3];
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(ak && wk)) begin
			@(negedge clk);
			ak = ak | (s_axi_awready === 1'b1);
			wk = wk | (s_axi_wready === 1'b1);
			@(posedge clk);
			if (ak) s_axi_awvalid <= 0;
			if (wk) s_axi_wvalid <= 0;
		end
		do @(negedge clk); while (s_axi_bvalid !== 1'b1);
		@(posedge clk) s_axi_bready <= 1;
		@(negedge clk) ck({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge clk) s_axi_bready <= 0;
	endtask
	// The master stalls one cycle on every answer so that holding is exercised.
	task automatic rc(input logic [31:0] a, e, input logic [1:0] er);
		logic [7:0] r;
		r = rb();
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arprot <= r[2:0];
		s_axi_arvalid <= 1;
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		@(posedge clk) s_axi_arvalid <= 0;
		do @(negedge clk); while (s_axi_rvalid !== 1'b1);
		@(posedge clk) s_axi_rready <= 1;
		@(negedge clk);
		ck(s_axi_rdata, e);
		ck({30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge clk) s_axi_rready <= 0;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		error_cnt++;
		$display("wrong value at %0t: watchdog expired", $time);
		test_done();
	end
	initial begin
		int b;
		logic [7:0] m, d, l, p, o, e;
		logic [31:0] a;
		repeat (10) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) ck(32'(pins(i)), 32'h0);
		rc(32'h04, 32'h0, 2'h0);
		$display("test reset done");
		for (int n = 0; n < 6; n++) begin
			for (int i = 0; i < 6; i++) begin
				b = (i == 0) ? 0 : i + 2;
				a = b * 32;
				m = (b == 3) ? 8'h0F : 8'hFF;
				d = (n == 0) ? m : (n == 1) ? 8'h00 : rb() & m;
				l = (n == 2) ? m : rb() & m;
				p = (b >= 3 && b <= 6) ? rb() & m : 8'h00;
				o = (b >= 3 && b <= 5) ? rb() & m : 8'h00;
				e = rb() & m;
				ext[b] <= e;
				wr(a, {24'h0, d}, 2'h0);
				wr(a + 4, {24'h0, l}, 2'h0);
				if (b >= 3 && b <= 6) wr(a + 12, {24'h0, p}, 2'h0);
				if (b >= 3 && b <= 5) wr(a + 16, {24'h0, o}, 2'h0);
				ck(32'(pins(b)), 32'(exp_pins(d, l, p, o)));
				rc(a, 32'h0, 2'h0);
				rc(a + 8, {24'h0, exp_view(d, l, p, e, m)}, 2'h0);
				wr(a + 8, {24'h0, ~l & m}, 2'h0);
				rc(a + 4, {24'h0, l}, 2'h0);
				if (b >= 3 && b <= 6) rc(a + 12, {24'h0, p}, 2'h0);
				if (b >= 3 && b <= 5) rc(a + 16, {24'h0, o}, 2'h0);
			end
		end
		$display("test banks done");
		repeat (4) begin
			d = rb();
			e = rb() & 8'h0F;
			p4_in <= d;
			p9_in <= e[3:0];
			rc(32'h28, {24'h0, d}, 2'h0);
			rc(32'h48, {24'h0, e}, 2'h0);
		end
		wr(32'h20, 32'hFF, 2'h2);
		rc(32'h44, 32'h0, 2'h2);
		$display("test input ports done");
		wr(32'h0C, 32'h01, 2'h2);
		rc(32'hD0, 32'h0, 2'h2);
		rc(32'h14, 32'h0, 2'h2);
		rc(32'h108, 32'h0, 2'h2);
		$display("test unmapped done");
		wr(32'h04, 32'hA5, 2'h0);
		s_axi_wstrb[0] <= 1'b0;
		wr(32'h04, 32'h5A, 2'h0);
		s_axi_wstrb[0] <= 1'b1;
		rc(32'h04, 32'hA5, 2'h0);
		$display("test strobe done");
		arst_n <= 0;
		repeat (2) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) ck(32'(pins(i)), 32'h0);
		rc(32'h04, 32'h0, 2'h0);
		$display("test second reset done");
		test_done();
	end
endmodule
`default_nettype wire
